// File: hw/itcp_pkg.sv
// Notes on behaviour
// - control word: select, format, mode, radix fields
// - select 00/01/10 counters, 11 readback
// - format 00 latch, 01 low, 10 high, 11 both
// - mode decode, top bit ignored modes 2,3
// - radix bit 0 binary, 1 decimal
// - count latch copies value, counting continues
// - two-byte format alternates pointer each access
// - readback: 11, count_n, state_n, picks, 0
// - count_freeze_n low latches picked counters together
// - snapshot_state_n low captures state byte per counter
// - pick bits 1..3 map counters zero..two
// - state byte: out, null, format, mode, radix
// - null flag set from write until loaded
// - state byte, then low, then high
// - further latches ignored until hold read out
// - state byte read before pending held count
// - three 16-bit down counters, count up to 65536 (zero loaded)
// - offset D write maps in, read maps out
package itcp_pkg;
  localparam logic [3:0] OFS_COUNTER0 = 4'h0;
  localparam logic [3:0] OFS_COUNTER1 = 4'h1;
  localparam logic [3:0] OFS_COUNTER2 = 4'h2;
  localparam logic [3:0] OFS_CONTROL = 4'h3;
  localparam logic [3:0] OFS_WINDOW = 4'hD;
  localparam int SEL_HI = 7;
  localparam int SEL_LO = 6;
  localparam int FMT_HI = 5;
  localparam int FMT_LO = 4;
  localparam int MODE_HI = 3;
  localparam int MODE_LO = 1;
  localparam int RADIX_BIT = 0;
  localparam int RB_COUNT_N = 5;
  localparam int RB_STATE_N = 4;
  localparam int RB_PICK_LO = 1;
  localparam logic [1:0] SEL_READBACK = 2'h3;
  localparam logic [1:0] FMT_LATCH = 2'h0;
  localparam logic [1:0] FMT_LOW = 2'h1;
  localparam logic [1:0] FMT_HIGH = 2'h2;
  localparam logic [1:0] FMT_BOTH = 2'h3;
  localparam logic [2:0] MODE_ONESHOT = 3'h1;
  localparam logic [2:0] MODE_RATE = 3'h2;
  localparam logic [2:0] MODE_SQUARE = 3'h3;
  localparam logic [2:0] MODE_SOFT = 3'h4;
  localparam logic [2:0] MODE_HARD = 3'h5;
  localparam logic [5:0] CFG_RESET = 6'h30;
  localparam int NUM_COUNTERS = 3;
endpackage

// File: hw/itcp_counter.sv
`timescale 1ns/1ps
// one down counter with its hold register and byte pointer
module itcp_counter (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // counter pins, already synchronised
  input wire logic tick,
  input wire logic gate,
  // host side
  input wire logic cfg_we,
  input wire logic [5:0] cfg_in,
  input wire logic freeze,
  input wire logic snap,
  input wire logic data_we,
  input wire logic data_re,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic out_level
);
  logic [5:0] cfg;
  logic [15:0] reload;
  logic [15:0] count;
  logic [15:0] hold;
  logic hold_full;
  logic hold_hi;
  logic [7:0] state_byte;
  logic state_full;
  logic ptr_hi;
  logic wr_hi;
  logic null_cnt;
  logic load_pend;
  logic armed;
  logic gate_q;
  logic [1:0] fmt;
  logic [2:0] mode;
  logic bcd;
  logic [15:0] dec_one;
  logic [15:0] dec_two;
  logic [15:0] rd_word;
  logic rd_hi;

  assign fmt = cfg[5:4];
  // codes x10 and x11 fold onto modes 2 and 3, so the top mode bit is a don't-care there
  assign mode = cfg[2] ? {1'b0, cfg[2:1]} : cfg[3:1];
  assign bcd = cfg[itcp_pkg::RADIX_BIT];

  // decimal-aware decrement, per nibble borrow
  function automatic logic [15:0] dec_val(input logic [15:0] v, input logic dec);
    logic [15:0] r;
    logic borrow;
    r = v;
    borrow = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (borrow) begin
        if (r[i*4 +: 4] == 4'h0) begin
          r[i*4 +: 4] = dec ? 4'h9 : 4'hF;
        end else begin
          r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
          borrow = 1'b0;
        end
      end
    end
    return r;
  endfunction

  assign dec_one = dec_val(count, bcd);
  assign dec_two = dec_val(dec_one, bcd);

  // configuration and host count writes
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cfg <= itcp_pkg::CFG_RESET;
      reload <= 16'h0000;
      ptr_hi <= 1'b0;
      wr_hi <= 1'b0;
      load_pend <= 1'b0;
    end else if (cfg_we) begin
      cfg <= cfg_in;
      ptr_hi <= 1'b0;
      wr_hi <= 1'b0;
      load_pend <= 1'b0;
    end else begin
      if (data_we) begin
        unique case (fmt)
          itcp_pkg::FMT_LOW: begin
            reload <= {8'h00, wdata};
            load_pend <= 1'b1;
          end
          itcp_pkg::FMT_HIGH: begin
            reload <= {wdata, 8'h00};
            load_pend <= 1'b1;
          end
          default: begin
            if (!wr_hi) reload[7:0] <= wdata;
            else reload[15:8] <= wdata;
            load_pend <= wr_hi;
            wr_hi <= ~wr_hi;
          end
        endcase
      end else if (load_pend) begin
        load_pend <= 1'b0;
      end
      if (data_re && !snap && !state_full && !hold_full && fmt == itcp_pkg::FMT_BOTH) begin
        ptr_hi <= ~ptr_hi;
      end
    end
  end

  // counting element, null flag and output
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      count <= 16'h0000;
      null_cnt <= 1'b0;
      armed <= 1'b0;
      out_level <= 1'b0;
      gate_q <= 1'b0;
    end else begin
      gate_q <= gate;
      if (cfg_we) begin
        null_cnt <= 1'b1;
        armed <= 1'b0;
        out_level <= (cfg_in[3:1] != 3'h0);
      end else if (data_we) begin
        null_cnt <= 1'b1;
      end else if (load_pend) begin
        count <= reload; // transfer ends null count
        null_cnt <= 1'b0;
        armed <= 1'b1;
        out_level <= (mode != 3'h0);
      end else if (armed && tick) begin
        if (gate || mode == itcp_pkg::MODE_ONESHOT || mode == itcp_pkg::MODE_HARD) begin
          if (mode == itcp_pkg::MODE_SQUARE) begin
            count <= (dec_two == 16'h0000) ? reload : dec_two;
            if (dec_two == 16'h0000) out_level <= ~out_level;
          end else if (mode == itcp_pkg::MODE_RATE) begin
            count <= (dec_one == 16'h0001) ? reload : dec_one;
            out_level <= (dec_one != 16'h0001);
          end else begin
            count <= dec_one;
            if (dec_one == 16'h0000) out_level <= (mode != itcp_pkg::MODE_SOFT);
            else if (mode == itcp_pkg::MODE_SOFT) out_level <= 1'b1;
          end
        end
        if (gate && !gate_q && (mode == itcp_pkg::MODE_ONESHOT || mode == itcp_pkg::MODE_HARD)) begin
          count <= reload; // retrigger
          out_level <= (mode == itcp_pkg::MODE_HARD);
        end
      end
    end
  end

  // hold register and state snapshot
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      hold <= 16'h0000;
      hold_full <= 1'b0;
      hold_hi <= 1'b0;
      state_byte <= 8'h00;
      state_full <= 1'b0;
    end else begin
      if (cfg_we) begin
        hold_full <= 1'b0;
        state_full <= 1'b0;
        hold_hi <= 1'b0;
      end else begin
        if (freeze && !hold_full) begin
          hold <= count;
          hold_full <= 1'b1;
          hold_hi <= (fmt == itcp_pkg::FMT_HIGH);
        end
        if (snap && !state_full) begin
          state_byte <= {out_level, null_cnt, cfg};
          state_full <= 1'b1;
        end
        if (data_re && state_full) begin
          state_full <= 1'b0;
        end else if (data_re && hold_full) begin
          if (fmt == itcp_pkg::FMT_BOTH && !hold_hi) begin
            hold_hi <= 1'b1;
          end else begin
            hold_full <= 1'b0;
          end
        end
      end
    end
  end

  // read data mux: state first, then hold, then live count
  assign rd_word = hold_full ? hold : count;
  assign rd_hi = hold_full ? hold_hi : (fmt == itcp_pkg::FMT_HIGH || (fmt == itcp_pkg::FMT_BOTH && ptr_hi));
  always_comb begin
    if (state_full) rdata = state_byte;
    else if (rd_hi) rdata = rd_word[15:8];
    else rdata = rd_word[7:0];
  end
endmodule

// File: hw/itcp_top.sv
`timescale 1ns/1ps
// command port and three counters behind a shared byte window
module itcp_top (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // host byte port, one-cycle strobes
  input wire logic [3:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic counters_mapped,
  // counter pins, asynchronous
  input wire logic [2:0] cnt_clk,
  input wire logic [2:0] cnt_gate,
  output logic [2:0] cnt_out
);
  localparam int N = itcp_pkg::NUM_COUNTERS;
  logic [2:0] clk_s1, clk_s2, clk_s3, gate_s1, gate_s2, gate_s3;
  logic [2:0] clk_st, gate_st, clk_prev, tick;
  logic [N-1:0] cfg_we, freeze, snap, data_we, data_re, out_w;
  logic [7:0] rd_w [N];
  logic is_ctrl, is_data;
  logic [1:0] sel;
  logic [2:0] picks;

  // three-stage pin synchronisers; a change counts once stages two and three agree
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      clk_s1 <= 3'h0;
      clk_s2 <= 3'h0;
      clk_s3 <= 3'h0;
      gate_s1 <= 3'h0;
      gate_s2 <= 3'h0;
      gate_s3 <= 3'h0;
      clk_st <= 3'h0;
      gate_st <= 3'h0;
      clk_prev <= 3'h0;
    end else begin
      clk_s1 <= cnt_clk;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      gate_s1 <= cnt_gate;
      gate_s2 <= gate_s1;
      gate_s3 <= gate_s2;
      clk_st <= (clk_s2 & clk_s3) | (clk_st & (clk_s2 | clk_s3));
      gate_st <= (gate_s2 & gate_s3) | (gate_st & (gate_s2 | gate_s3));
      clk_prev <= clk_st;
    end
  end
  assign tick = clk_st & ~clk_prev;

  // window mapping: write maps in, read maps out, nothing else reset
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      counters_mapped <= 1'b0;
    end else if (addr == itcp_pkg::OFS_WINDOW && wr_en) begin
      counters_mapped <= 1'b1;
    end else if (addr == itcp_pkg::OFS_WINDOW && rd_en) begin
      counters_mapped <= 1'b0;
    end
  end

  // command decode
  assign is_ctrl = counters_mapped && wr_en && addr == itcp_pkg::OFS_CONTROL;
  assign is_data = counters_mapped && addr < itcp_pkg::OFS_CONTROL;
  assign sel = wdata[itcp_pkg::SEL_HI:itcp_pkg::SEL_LO];
  assign picks = wdata[itcp_pkg::RB_PICK_LO +: 3];
  always_comb begin
    for (int i = 0; i < N; i++) begin
      cfg_we[i] = is_ctrl && sel == 2'(i) && wdata[5:4] != itcp_pkg::FMT_LATCH;
      freeze[i] = is_ctrl && ((sel == 2'(i) && wdata[5:4] == itcp_pkg::FMT_LATCH)
        || (sel == itcp_pkg::SEL_READBACK && picks[i] && !wdata[itcp_pkg::RB_COUNT_N]));
      snap[i] = is_ctrl && sel == itcp_pkg::SEL_READBACK && picks[i]
        && !wdata[itcp_pkg::RB_STATE_N];
      data_we[i] = is_data && wr_en && addr == 4'(i);
      data_re[i] = is_data && rd_en && addr == 4'(i);
    end
  end

  // counters, one instance each
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_cnt
      itcp_counter u_cnt (
        .mclk(mclk),
        .rstn(rstn),
        .tick(tick[g]),
        .gate(gate_st[g]),
        .cfg_we(cfg_we[g]),
        .cfg_in(wdata[5:0]),
        .freeze(freeze[g]),
        .snap(snap[g]),
        .data_we(data_we[g]),
        .data_re(data_re[g]),
        .wdata(wdata),
        .rdata(rd_w[g]),
        .out_level(out_w[g])
      );
    end
  endgenerate

  // registered outputs; read data valid the cycle after rd_en
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdata <= 8'h00;
      cnt_out <= 3'h0;
    end else begin
      cnt_out <= out_w;
      if (rd_en && is_data) rdata <= rd_w[addr[1:0]];
      else if (rd_en) rdata <= 8'h00;
    end
  end
endmodule

// File: sim/itcp_top_asserts.sv
`timescale 1ns/1ps
// port-level checker for the command port
module itcp_top_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // host byte port
  input wire logic [3:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic counters_mapped,
  // counter pins
  input wire logic [2:0] cnt_clk,
  input wire logic [2:0] cnt_gate,
  input wire logic [2:0] cnt_out
);
  logic [5:0] cfg [3];
  logic ctl_wr;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  assign ctl_wr = wr_en && counters_mapped && addr == 4'h3;
  // mirror of programmed fields; latch words leave them alone
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 3; i++) begin
      if (!rstn) begin
        cfg[i] <= itcp_pkg::CFG_RESET;
      end else if (ctl_wr && wdata[7:6] == i[1:0] && wdata[5:4] != 2'h0) begin
        cfg[i] <= wdata[5:0];
      end
    end
  end
  a_map_in: assert property (wr_en && addr == 4'hD |=> counters_mapped)
    else $error("window write did not map counters in");
  a_map_out: assert property (rd_en && addr == 4'hD |=> !counters_mapped)
    else $error("window read did not map counters out");
  a_map_steady: assert property (!((wr_en || rd_en) && addr == 4'hD) |=> $stable(counters_mapped))
    else $error("window moved without a window access");
  a_refuse_read: assert property (rd_en && !counters_mapped && addr <= 4'h3 |=> rdata == 8'h00)
    else $error("unmapped read returned data");
  a_rdata_holds: assert property (!rd_en |=> $stable(rdata))
    else $error("read data changed without a read");
  a_state_ctr_zero: assert property (ctl_wr && wdata == 8'hE2 ##[1:2] rd_en && addr == 4'h0 |=> rdata[5:0] == cfg[0])
    else $error("counter zero state byte fields wrong");
  a_state_ctr_one: assert property (ctl_wr && wdata == 8'hE4 ##[1:2] rd_en && addr == 4'h1 |=> rdata[5:0] == cfg[1])
    else $error("counter one state byte fields wrong");
  a_state_ctr_two: assert property (ctl_wr && wdata == 8'hE8 ##[1:2] rd_en && addr == 4'h2 |=> rdata[5:0] == cfg[2])
    else $error("counter two state byte fields wrong");
endmodule

bind itcp_top itcp_top_chk u_itcp_top_chk (.mclk, .rstn, .addr, .wr_en, .rd_en, .wdata, .rdata,
  .counters_mapped, .cnt_clk, .cnt_gate, .cnt_out);

// File: sim/itcp_host.sv
`timescale 1ns/1ps
// stand-in for the processor on the byte port
module itcp_host (
  // clock
  input wire logic mclk,
  // byte port
  output logic [3:0] addr,
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  // idle bus at time zero
  initial begin
    addr = 4'hA;
    wr_en = 1'b0;
    rd_en = 1'b0;
    wdata = 8'h00;
  end
  // one write; count bytes come in low, high pairs from the caller
  task automatic put(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(posedge mclk);
    #1;
    wr_en = 1'b0;
    addr = ~a; // released lines must not look valid
    wdata = ~d;
  endtask
  // one read; data is taken a cycle later since it holds until the next read
  task automatic get(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1;
    addr = a;
    rd_en = 1'b1;
    @(posedge mclk);
    #1;
    rd_en = 1'b0;
    addr = ~a;
    @(posedge mclk);
    #1;
    d = rdata;
  endtask
endmodule

// File: sim/interval_timer_command_port_bench.sv
`timescale 1ns/1ps
// drives the command port through the host stand-in
module interval_timer_command_port_bench;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] addr;
  logic wr_en;
  logic rd_en;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic counters_mapped;
  logic [2:0] cnt_clk = 3'h0;
  logic [2:0] cnt_gate = 3'h0;
  logic [2:0] cnt_out;
  int n_errors = 0;
  int num_checks = 0;
  // free-running 125 MHz clock
  always #4 mclk = ~mclk;
  itcp_top u_itcp_top (.mclk, .rstn, .addr, .wr_en, .rd_en, .wdata, .rdata, .counters_mapped,
    .cnt_clk, .cnt_gate, .cnt_out);
  itcp_host u_itcp_host (.mclk, .addr, .wr_en, .rd_en, .wdata, .rdata);
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] got;
    u_itcp_host.get(a, got);
    chk(what, exp, got);
  endtask
  // slow pulses on counter zero's clock pin, wide enough for the synchroniser
  task automatic pulse(input int n);
    repeat (n) begin
      repeat (4) @(posedge mclk);
      #1 cnt_clk[0] = 1'b1;
      repeat (4) @(posedge mclk);
      #1 cnt_clk[0] = 1'b0;
    end
    repeat (6) @(posedge mclk);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic t_window;
    rd_chk("unmapped read", 4'h0, 8'h00);
    u_itcp_host.put(4'hD, 8'h5A);
    chk("mapped", 8'h01, {7'h0, counters_mapped});
    $display("window test done");
  endtask
  task automatic t_latch;
    u_itcp_host.put(4'h3, 8'h30);
    u_itcp_host.put(4'h0, 8'h34);
    u_itcp_host.put(4'h0, 8'h12);
    rd_chk("direct low", 4'h0, 8'h34);
    rd_chk("direct high", 4'h0, 8'h12);
    u_itcp_host.put(4'h3, 8'h00);
    cnt_gate[0] = 1'b1;
    pulse(3);
    u_itcp_host.put(4'h3, 8'h00);
    rd_chk("held low", 4'h0, 8'h34);
    rd_chk("held high", 4'h0, 8'h12);
    cnt_gate[0] = 1'b0;
    u_itcp_host.put(4'h3, 8'h00);
    rd_chk("moved low", 4'h0, 8'h31);
    rd_chk("moved high", 4'h0, 8'h12);
    $display("latch test done");
  endtask
  task automatic t_readback;
    u_itcp_host.put(4'h3, 8'h70);
    u_itcp_host.put(4'h1, 8'hEF);
    u_itcp_host.put(4'h1, 8'hBE);
    u_itcp_host.put(4'h3, 8'hC6);
    rd_chk("state c0", 4'h0, 8'h30);
    rd_chk("low c0", 4'h0, 8'h31);
    rd_chk("high c0", 4'h0, 8'h12);
    rd_chk("state c1", 4'h1, 8'h30);
    rd_chk("low c1", 4'h1, 8'hEF);
    rd_chk("high c1", 4'h1, 8'hBE);
    u_itcp_host.put(4'h3, 8'h00);
    u_itcp_host.put(4'h3, 8'hE2);
    rd_chk("late state", 4'h0, 8'h30);
    rd_chk("late low", 4'h0, 8'h31);
    rd_chk("late high", 4'h0, 8'h12);
    $display("readback test done");
  endtask
  task automatic t_fields;
    logic [7:0] w;
    logic [7:0] got;
    for (int i = 0; i < 6; i++) begin
      w = {2'(i % 3), 2'(1 + i % 3), 3'(i), 1'(i % 2)};
      u_itcp_host.put(4'h3, w);
      u_itcp_host.put(4'h3, 8'hE0 | (8'h02 << (i % 3)));
      u_itcp_host.get(4'(i % 3), got);
      chk("state fields", {2'h1, w[5:0]}, got & 8'h7F);
    end
    $display("fields test done");
  endtask
  // decimal stepping, mode 0 terminal output, and mode 2 reached through code 110
  task automatic t_modes;
    cnt_gate[0] = 1'b1;
    u_itcp_host.put(4'h3, 8'h11);
    u_itcp_host.put(4'h0, 8'h10);
    pulse(1);
    u_itcp_host.put(4'h3, 8'h00);
    rd_chk("decimal step", 4'h0, 8'h09);
    chk("out before zero", 8'h00, {7'h0, cnt_out[0]});
    pulse(9);
    chk("out at zero", 8'h01, {7'h0, cnt_out[0]});
    u_itcp_host.put(4'h3, 8'h1C);
    u_itcp_host.put(4'h0, 8'h03);
    pulse(2);
    chk("rate low", 8'h00, {7'h0, cnt_out[0]});
    cnt_gate[0] = 1'b0;
    $display("modes test done");
  endtask
  task automatic t_unmap;
    logic [7:0] got;
    u_itcp_host.get(4'hD, got);
    chk("unmapped", 8'h00, {7'h0, counters_mapped});
    rd_chk("refused read", 4'h1, 8'h00);
    $display("unmap test done");
  endtask
  // main sequence after six reset cycles
  initial begin
    repeat (6) @(posedge mclk);
    #1 rstn = 1'b1;
    t_window();
    t_latch();
    t_readback();
    t_fields();
    t_modes();
    t_unmap();
    give_verdict();
  end
  // cuts a hang short; the tests need about 300 cycles
  initial begin
    #200000;
    n_errors++;
    $display("watchdog expired");
    give_verdict();
  end
endmodule
